/* core/mpsc_pkg.sv */
package mpsc_pkg;
   localparam logic [7:0] MPSC_OFS_DATA = 8'h00;
   localparam logic [7:0] MPSC_OFS_STATUS = 8'h01;
   localparam logic [7:0] MPSC_OFS_CONTROL = 8'h02;
   localparam logic [7:0] MPSC_ADDR_DATA = 8'h00;
   localparam logic [7:0] MPSC_ADDR_STATUS = 8'h04;
   localparam logic [7:0] MPSC_ADDR_CONTROL = 8'h08;
   localparam logic [7:0] MPSC_CTL_RESET = 8'h09;
   localparam logic [7:0] MPSC_CTL_WMASK = 8'hDF;
   localparam int MPSC_ST_RX_EMPTY = 7;
   localparam int MPSC_ST_TX_FULL = 6;
   localparam int MPSC_ST_RX_FULL = 5;
   localparam int MPSC_ST_MODE = 4;
   localparam int MPSC_ST_OVERRUN = 3;
   localparam int MPSC_ST_TX_NEMPTY = 2;
   localparam int MPSC_CT_LOOP = 7;
   localparam int MPSC_CT_THRU = 6;
   localparam int MPSC_CT_PT_TX = 4;
   localparam int MPSC_CT_RX_IE = 3;
   localparam int MPSC_CT_MASK = 2;
   localparam int MPSC_CT_TX_IE = 1;
   localparam int MPSC_CT_PT_FIFO = 0;
   localparam logic [7:0] MPSC_CMD_UART = 8'h3F;
   localparam logic [7:0] MPSC_CMD_RESET = 8'hFF;
   localparam logic [7:0] MPSC_ACK = 8'hFE;
   localparam int MPSC_FIFO_DEPTH = 16;
   localparam int MPSC_RX_THRESH = 8;
   localparam int MPSC_TX_REFILL = 3;
   localparam int MPSC_CLK_HZ = 20000000;
   localparam int MPSC_BAUD = 31250;
   localparam int MPSC_BIT_CYC = MPSC_CLK_HZ / MPSC_BAUD;
   localparam int MPSC_TIMEOUT_US = 1280;
   localparam int MPSC_TIMEOUT_CYC = (MPSC_CLK_HZ / 1000000) * MPSC_TIMEOUT_US;
endpackage

/* core/mpsc_port.sv */
// Overview of operation
// - Status bit 7 is 1 when receive store is empty; resets 1.
// - Status bit 6 is 1 when transmit store cannot take a byte.
// - Status bit 5 shows receive FIFO full, zero when FIFOs disabled.
// - Status bit 4 shows mode: 1 UART, 0 passthrough (reset).
// - Status bit 3 sets when a byte arrives while receive is full.
// - Reading status clears the overrun flag.
// - Status bit 2 shows transmit FIFO not empty, zero when disabled.
// - Write to 01h is a command; read of 01h returns status.
// - Control bit 7 loops transmit signal into receive path.
// - Control bit 6 drives serial output from serial input unless bit 2 is set.
// - Without thru or mask, serial output carries own transmit engine.
// - Passthrough transmit only when control bit 4 set; resets 0.
// - Control bit 3 gates receive-ready interrupt; resets 1.
// - Control bit 2 holds serial output high; resets 0.
// - Control bit 1 gates transmit-empty interrupt; resets 0.
// - Control bit 0 enables receive FIFO in passthrough; resets 1.
// - UART mode ignores the passthrough FIFO enable bit.
// - UART receive interrupt while eight or more bytes are unread.
// - Receive interrupt after 1.28 ms idle with fewer than eight.
// - UART transmit interrupt when empty, drops at three bytes.
module mpsc_port
   import mpsc_pkg::*;
#(
   parameter int DEPTH = MPSC_FIFO_DEPTH,
   parameter int BIT_CYC = MPSC_BIT_CYC,
   parameter int TIMEOUT_CYC = MPSC_TIMEOUT_CYC
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic serial_in_pin,
   output logic serial_out_pin,
   output logic irq
);
   import mpsc_pkg::*;

   localparam int AW = $clog2(DEPTH);
   localparam int CW = AW + 1;
   localparam logic [CW-1:0] FULL_LVL = CW'(DEPTH);
   localparam logic [CW-1:0] RX_TH = CW'(MPSC_RX_THRESH);
   localparam logic [CW-1:0] TX_RF = CW'(MPSC_TX_REFILL);
   localparam logic [15:0] BIT_C = 16'(BIT_CYC - 1);
   localparam logic [15:0] HALF_C = 16'(BIT_CYC / 2);

   typedef enum logic [1:0] {SER_IDLE = 2'b00, SER_START = 2'b01,
      SER_DATA = 2'b11, SER_STOP = 2'b10} mpsc_ser_t;

   // Register state
   logic [7:0] ctl_q;
   logic uart_q;
   logic ovr_q;
   logic [31:0] prdata_q;
   logic pready_q;
   logic pslverr_q;
   logic out_q;
   logic irq_q;
   logic [7:0] rx_mem_q [DEPTH];
   logic [7:0] tx_mem_q [DEPTH];
   logic [AW-1:0] rx_rd_q, rx_wr_q, tx_rd_q, tx_wr_q;
   logic [CW-1:0] rx_cnt_q, tx_cnt_q;
   logic [1:0] rx_sync_q;
   logic [31:0] tmo_q;
   logic tmo_hit_q;
   logic tx_irq_q;

   // Transmit and receive engines
   mpsc_ser_t tx_st_q, rx_st_q;
   logic [15:0] tx_div_q, rx_div_q;
   logic [2:0] tx_bit_q, rx_bit_q;
   logic [7:0] tx_sh_q, rx_sh_q;
   logic tx_line_q;

   // APB decode
   wire acc = psel && penable && !pready_q;
   wire hit_data = paddr == MPSC_ADDR_DATA;
   wire hit_stat = paddr == MPSC_ADDR_STATUS;
   wire hit_ctl = paddr == MPSC_ADDR_CONTROL;
   wire mapped = hit_data || hit_stat || hit_ctl;
   wire wr_data = acc && pwrite && hit_data;
   wire wr_cmd = acc && pwrite && hit_stat;
   wire wr_ctl = acc && pwrite && hit_ctl;
   wire rd_data = acc && !pwrite && hit_data;
   wire rd_stat = acc && !pwrite && hit_stat;

   // Mode and FIFO enables; UART ignores control bit 0
   wire fifo_en = uart_q || ctl_q[MPSC_CT_PT_FIFO];
   wire [CW-1:0] rx_cap = fifo_en ? FULL_LVL : CW'(1);
   wire [CW-1:0] tx_cap = uart_q ? FULL_LVL : CW'(1);
   wire rx_empty = rx_cnt_q == '0;
   wire rx_full = rx_cnt_q >= rx_cap;
   wire tx_full = tx_cnt_q >= tx_cap;
   wire tx_empty = tx_cnt_q == '0;

   wire [7:0] status = {rx_empty,
      tx_full,
      fifo_en && rx_full,
      uart_q,
      ovr_q,
      uart_q && !tx_empty,
      2'b00};

   // Commands: enter UART mode with ack byte unless receive store is full, reset to passthrough; reset acks only when already in passthrough
   wire cmd_uart = wr_cmd && pwdata[7:0] == MPSC_CMD_UART && !uart_q;
   wire cmd_rst = wr_cmd && pwdata[7:0] == MPSC_CMD_RESET;
   wire ack_push = (cmd_uart || (cmd_rst && !uart_q)) && !rx_full;

   // Serial routing
   wire rx_pin = rx_sync_q[1];
   wire rx_line = ctl_q[MPSC_CT_LOOP] ? tx_line_q : rx_pin;
   wire out_d = ctl_q[MPSC_CT_MASK] ? 1'b1 :
      ctl_q[MPSC_CT_THRU] ? rx_pin :
      tx_line_q;

   // Transmit is allowed in UART mode or with passthrough transmit enabled
   wire tx_go = uart_q || ctl_q[MPSC_CT_PT_TX];
   wire tx_pop = tx_st_q == SER_IDLE && !tx_empty && tx_go;
   wire tx_push = wr_data && !tx_full;
   wire rx_tick = rx_div_q == '0;
   wire rx_done = rx_st_q == SER_STOP && rx_tick;
   wire rx_byte = rx_done && rx_line;
   wire rx_push = (rx_byte && !rx_full) || ack_push;
   wire rx_ovr = rx_byte && rx_full;
   wire rx_pop = rd_data && !rx_empty;
   wire [7:0] rx_in = ack_push ? MPSC_ACK : rx_sh_q;

   // Interrupt sources
   wire rx_ready = uart_q ? (rx_cnt_q >= RX_TH) :
      (fifo_en ? rx_cnt_q >= RX_TH : !rx_empty);
   wire rx_irq = ctl_q[MPSC_CT_RX_IE] && (rx_ready || tmo_hit_q);
   wire tx_irq = ctl_q[MPSC_CT_TX_IE] &&
      (uart_q ? tx_irq_q : tx_empty);
   wire rx_act = rx_byte || rx_pop;

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign serial_out_pin = out_q;
   assign irq = irq_q;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctl_q <= MPSC_CTL_RESET;
         uart_q <= 1'b0;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= '0;
      end
      else if (clk_en)
      begin
         pready_q <= psel && penable && !pready_q;
         pslverr_q <= acc && !mapped;
         if (wr_ctl)
            ctl_q <= pwdata[7:0] & MPSC_CTL_WMASK;
         if (cmd_uart)
            uart_q <= 1'b1;
         else if (cmd_rst)
            uart_q <= 1'b0;
         if (acc && !pwrite)
            prdata_q <= hit_stat ? {24'h0, status} :
               hit_ctl ? {24'h0, ctl_q} :
               hit_data ? {24'h0, rx_mem_q[rx_rd_q]} : '0;
      end
   end

   // Overrun: a new overrun in the read cycle wins over the clear
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ovr_q <= 1'b0;
      else if (clk_en)
      begin
         if (rx_ovr)
            ovr_q <= 1'b1;
         else if (rd_stat)
            ovr_q <= 1'b0;
      end
   end

   // Receive store
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rx_rd_q <= '0;
         rx_wr_q <= '0;
         rx_cnt_q <= '0;
      end
      else if (clk_en)
      begin
         if (cmd_rst || cmd_uart)
         begin
            rx_rd_q <= '0;
            rx_wr_q <= AW'(ack_push);
            rx_cnt_q <= CW'(ack_push);
         end
         else
         begin
            if (rx_push)
               rx_wr_q <= rx_wr_q + 1'b1;
            if (rx_pop)
               rx_rd_q <= rx_rd_q + 1'b1;
            rx_cnt_q <= rx_cnt_q + CW'(rx_push) - CW'(rx_pop);
         end
      end
   end

   always_ff @(posedge pclk)
   begin
      if (clk_en && rx_push)
         rx_mem_q[(cmd_rst || cmd_uart) ? '0 : rx_wr_q] <= rx_in;
   end

   // Transmit store
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         tx_rd_q <= '0;
         tx_wr_q <= '0;
         tx_cnt_q <= '0;
      end
      else if (clk_en)
      begin
         if (cmd_rst || cmd_uart)
         begin
            tx_rd_q <= '0;
            tx_wr_q <= '0;
            tx_cnt_q <= '0;
         end
         else
         begin
            if (tx_push)
               tx_wr_q <= tx_wr_q + 1'b1;
            if (tx_pop)
               tx_rd_q <= tx_rd_q + 1'b1;
            tx_cnt_q <= tx_cnt_q + CW'(tx_push) - CW'(tx_pop);
         end
      end
   end

   always_ff @(posedge pclk)
   begin
      if (clk_en && tx_push)
         tx_mem_q[tx_wr_q] <= pwdata[7:0];
   end

   // Transmit engine: start bit, eight data bits LSB first, stop bit
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         tx_st_q <= SER_IDLE;
         tx_div_q <= '0;
         tx_bit_q <= '0;
         tx_sh_q <= '0;
         tx_line_q <= 1'b1;
      end
      else if (clk_en)
      begin
         if (tx_st_q != SER_IDLE)
            tx_div_q <= (tx_div_q == '0) ? BIT_C : tx_div_q - 1'b1;
         unique case (tx_st_q)
            SER_IDLE:
               if (tx_pop)
               begin
                  tx_sh_q <= tx_mem_q[tx_rd_q];
                  tx_line_q <= 1'b0;
                  tx_div_q <= BIT_C;
                  tx_st_q <= SER_START;
               end
            SER_START:
               if (tx_div_q == '0)
               begin
                  tx_line_q <= tx_sh_q[0];
                  tx_bit_q <= '0;
                  tx_st_q <= SER_DATA;
               end
            SER_DATA:
               if (tx_div_q == '0)
               begin
                  if (tx_bit_q == 3'd7)
                  begin
                     tx_line_q <= 1'b1;
                     tx_st_q <= SER_STOP;
                  end
                  else
                  begin
                     tx_line_q <= tx_sh_q[tx_bit_q + 3'd1];
                     tx_bit_q <= tx_bit_q + 3'd1;
                  end
               end
            SER_STOP:
               if (tx_div_q == '0)
                  tx_st_q <= SER_IDLE;
         endcase
      end
   end

   // Receive engine samples mid-bit
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rx_sync_q <= 2'b11;
         rx_st_q <= SER_IDLE;
         rx_div_q <= '0;
         rx_bit_q <= '0;
         rx_sh_q <= '0;
      end
      else if (clk_en)
      begin
         rx_sync_q <= {rx_sync_q[0], serial_in_pin};
         if (rx_st_q != SER_IDLE)
            rx_div_q <= rx_tick ? BIT_C : rx_div_q - 1'b1;
         unique case (rx_st_q)
            SER_IDLE:
               if (!rx_line)
               begin
                  rx_div_q <= HALF_C;
                  rx_st_q <= SER_START;
               end
            SER_START:
               if (rx_tick)
               begin
                  rx_bit_q <= '0;
                  rx_st_q <= rx_line ? SER_IDLE : SER_DATA;
               end
            SER_DATA:
               if (rx_tick)
               begin
                  rx_sh_q <= {rx_line, rx_sh_q[7:1]};
                  rx_bit_q <= rx_bit_q + 3'd1;
                  if (rx_bit_q == 3'd7)
                     rx_st_q <= SER_STOP;
               end
            SER_STOP:
               if (rx_tick)
                  rx_st_q <= SER_IDLE;
         endcase
      end
   end

   // Idle timeout, transmit refill hysteresis and interrupt output
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         tmo_q <= '0;
         tmo_hit_q <= 1'b0;
         tx_irq_q <= 1'b1;
         irq_q <= 1'b0;
         out_q <= 1'b1;
      end
      else if (clk_en)
      begin
         out_q <= out_d;
         if (rx_act || rx_empty || !fifo_en || rx_cnt_q >= RX_TH)
         begin
            tmo_q <= '0;
            tmo_hit_q <= 1'b0;
         end
         else if (tmo_q == 32'(TIMEOUT_CYC - 1))
            tmo_hit_q <= 1'b1;
         else
            tmo_q <= tmo_q + 32'd1;
         if (tx_empty)
            tx_irq_q <= 1'b1;
         else if (tx_cnt_q >= TX_RF)
            tx_irq_q <= 1'b0;
         irq_q <= rx_irq || tx_irq;
      end
   end
endmodule

/* verif/midi_port_status_control_tb.sv */
module midi_port_status_control_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import mpsc_pkg::*;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rd;
   logic pready, pslverr, sin, sout, irq, err;
   int miscompares = 0, compares = 0, lows = 0;
   localparam int BIT_CYC = 16;
   localparam int TMO_CYC = 400;
   logic clk_en = 1'b1;
   always #25 pclk = ~pclk;
   always @(posedge pclk) if (sout === 1'b0) lows++;
   mpsc_port #(.BIT_CYC(BIT_CYC), .TIMEOUT_CYC(TMO_CYC)) i_mpsc_port (
      .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .serial_in_pin(sin), .serial_out_pin(sout), .irq(irq));
   mpsc_midi_dev #(.BIT_CYC(BIT_CYC)) i_mpsc_midi_dev (
      .pclk(pclk), .line_in(sout), .line_out(sin));
   task automatic summarize;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, exp, input string s);
      compares++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", s, exp, seen);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1)
      begin
         miscompares++;
         summarize();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] e, string s);
      bus(1'b0, a, 32'h0);
      chk(rd, e, s);
   endtask
   task automatic wait_rx(input int k);
      int n;
      for (n = 0; n < 2000 && i_mpsc_midi_dev.got.size() < k; n++)
         @(posedge pclk);
      if (n == 2000)
      begin
         miscompares++;
         summarize();
      end
   endtask
   initial
   begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rdc(8'h04, 32'h80, "status reset");
      rdc(8'h08, 32'h09, "control reset");
      wr(8'h08, 32'hFF);
      rdc(8'h08, 32'hDF, "control bit5");
      bus(1'b0, 8'h0C, 32'h0);
      chk(err, 1, "unmapped");
      wr(8'h08, 32'h09);
      wr(8'h04, 32'hFF);
      rdc(8'h04, 32'h00, "status ack");
      rdc(8'h00, 32'hFE, "ack byte");
      $display("test regs done");
      wr(8'h08, 32'h00);
      wr(8'h00, 32'h55);
      repeat (300) @(posedge pclk);
      chk(i_mpsc_midi_dev.got.size(), 0, "pt tx off");
      rdc(8'h04, 32'hC0, "tx held");
      wr(8'h08, 32'h10);
      wait_rx(1);
      chk(i_mpsc_midi_dev.got.pop_front(), 32'h55, "pt tx");
      wr(8'h08, 32'h14);
      lows = 0;
      wr(8'h00, 32'h3C);
      repeat (300) @(posedge pclk);
      chk(lows, 0, "mask");
      rdc(8'h04, 32'h80, "mask sent");
      wr(8'h08, 32'h40);
      i_mpsc_midi_dev.send(8'hC3);
      wait_rx(1);
      chk(i_mpsc_midi_dev.got.pop_front(), 32'hC3, "thru");
      rdc(8'h00, 32'hC3, "thru rx");
      $display("test pins done");
      wr(8'h08, 32'h00);
      i_mpsc_midi_dev.send(8'h11);
      i_mpsc_midi_dev.send(8'h22);
      repeat (20) @(posedge pclk);
      rdc(8'h04, 32'h08, "overrun");
      rdc(8'h04, 32'h00, "overrun clr");
      rdc(8'h00, 32'h11, "kept byte");
      wr(8'h08, 32'h90);
      wr(8'h00, 32'h5A);
      repeat (400) @(posedge pclk);
      rdc(8'h00, 32'h5A, "loopback");
      $display("test rx done");
      i_mpsc_midi_dev.got.delete();
      wr(8'h04, 32'h3F);
      bus(1'b0, 8'h04, 32'h0);
      chk(rd[4], 1, "uart mode");
      if (rd[7] === 1'b0) bus(1'b0, 8'h00, 32'h0);
      wr(8'h08, 32'h08);
      for (int i = 0; i < 17; i++)
      begin
         i_mpsc_midi_dev.send(i[7:0]);
         repeat (20) @(posedge pclk);
         if (i == 6) chk(irq, 0, "seven");
         if (i == 7) chk(irq, 1, "eight");
         if (i == 15) rdc(8'h04, 32'h30, "rx full");
      end
      rdc(8'h04, 32'h38, "uart overrun");
      for (int i = 0; i < 9; i++)
         rdc(8'h00, i, "fifo order");
      repeat (3) @(posedge pclk);
      chk(irq, 0, "below eight");
      clk_en <= 1'b0;
      repeat (420) @(posedge pclk);
      chk(irq, 0, "frozen");
      clk_en <= 1'b1;
      repeat (420) @(posedge pclk);
      chk(irq, 1, "timeout");
      wr(8'h08, 32'h02);
      repeat (3) @(posedge pclk);
      chk(irq, 1, "tx empty");
      for (int i = 0; i < 4; i++)
      begin
         wr(8'h00, 32'hA0 + i);
         if (i == 2) chk(irq, 1, "tx two");
      end
      repeat (2) @(posedge pclk);
      chk(irq, 0, "tx refill");
      bus(1'b0, 8'h04, 32'h0);
      chk(rd[2], 1, "tx not empty");
      wait_rx(4);
      for (int i = 0; i < 4; i++)
         chk(i_mpsc_midi_dev.got[i], 32'hA0 + i, "uart tx");
      wr(8'h04, 32'hFF);
      bus(1'b0, 8'h04, 32'h0);
      chk(rd[4], 0, "back to pt");
      $display("test uart done");
      summarize();
   end
endmodule

/* verif/mpsc_midi_dev.sv */
module mpsc_midi_dev #(
   parameter int BIT_CYC = 16
)
(
   input wire logic pclk,
   input wire logic line_in,
   output logic line_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] got[$];
   initial line_out = 1'b1;
   // One 8N1 frame, line left idle high after the stop bit
   task automatic send(input logic [7:0] b);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++)
      begin
         line_out <= f[i];
         repeat (BIT_CYC) @(posedge pclk);
      end
   endtask
   always
   begin : rx
      logic [7:0] b;
      @(negedge line_in);
      repeat (BIT_CYC / 2) @(posedge pclk);
      for (int i = 0; i < 8; i++)
      begin
         repeat (BIT_CYC) @(posedge pclk);
         b[i] = line_in;
      end
      repeat (BIT_CYC) @(posedge pclk);
      got.push_back(b);
   end
endmodule

/* verif/mpsc_port_assertions.sv */
module mpsc_port_assertions (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic serial_in_pin,
   input wire logic serial_out_pin,
   input wire logic irq
);
   logic [7:0] ctl_q;
   logic mode_q;
   wire wr_ack = pready && pwrite;
   wire rd_ack = pready && !pwrite;
   wire cmd_wr = wr_ack && paddr == 8'h04;
   wire irq_off = !ctl_q[3] && !ctl_q[1];
   // Shadow of control and mode, built from completed bus writes
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctl_q <= 8'h09;
         mode_q <= 1'b0;
      end
      else if (wr_ack && paddr == 8'h08)
         ctl_q <= pwdata[7:0] & 8'hDF;
      else if (cmd_wr && pwdata[7:0] == 8'h3F)
         mode_q <= 1'b1;
      else if (cmd_wr && pwdata[7:0] == 8'hFF)
         mode_q <= 1'b0;
   end
   default clocking @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   a_ready_one_wait: assert property (
      psel && penable && !pready && clk_en |=> pready)
      else $error("pready not one cycle into access");
   a_ready_pulse: assert property (
      pready && clk_en |=> !pready)
      else $error("pready longer than one cycle");
   a_unmapped_err: assert property (
      pready |-> pslverr == !(paddr inside {8'h00, 8'h04, 8'h08}))
      else $error("pslverr wrong for address");
   a_err_reads_zero: assert property (
      rd_ack && pslverr |-> prdata == 32'h0)
      else $error("refused read returned data");
   a_status_bits: assert property (
      rd_ack && paddr == 8'h04 |-> prdata[4] == mode_q
         && prdata[1:0] == 2'b00 && prdata[31:8] == 24'h0)
      else $error("status mode or reserved bits wrong");
   a_ctl_readback: assert property (
      rd_ack && paddr == 8'h08 |-> prdata == {24'h0, ctl_q})
      else $error("control readback wrong");
   a_mask_high: assert property (
      ctl_q[2] && !ctl_q[6] && $past(ctl_q[2]) |-> serial_out_pin)
      else $error("masked serial output went low");
   a_irq_gated: assert property (
      irq_off && $past(irq_off) |-> !irq)
      else $error("irq raised with both enables off");
endmodule

bind mpsc_port mpsc_port_assertions i_mpsc_port_assertions (
   .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin),
   .irq(irq));
